/* hw/fps_host.sv */
/*
 * Host controller for a byte-wide flash: runs program, sector erase,
 * suspend, resume, reset and status polling sequences on the flash pins,
 * ordered and observed through a classic Wishbone slave.
 * Assumes flash pins synchronous to clk_i; the bench wires pins_o.dq and fl_dq_i separately, with no shared dq wire.
 */
// Chosen here: the Wishbone register port and the register offsets.
// Overview of operation
// - Poll at program address or erasing sector
// - Take valid byte on read after true
// - Valid address on polling reads; toggle static
// - Wait 10ms after resume before suspending
// - Program: two unlocks, A0, address and data
// - B0 suspends; other commands end load window
`timescale 1ns/10ps
`default_nettype none
module fps_host #(
	parameter int GAP_CYC_P = fps_pkg::GAP_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output fps_pkg::fps_pins_t pins_o,
	input wire logic [7:0] fl_dq_i
);
	import fps_pkg::*;

	fps_host_t st;
	fps_host_t nx;

	// ----------------------------------------
	// Command tables
	// ----------------------------------------
	// Number of command writes that each operation issues
	function automatic logic [2:0] nwr(input fps_op_t op);
		unique case (op)
			OP_PROG: nwr = 3'h4;
			OP_ERASE: nwr = 3'h6;
			OP_SUSP, OP_RESUME, OP_RESET: nwr = 3'h1;
			default: nwr = 3'h0;
		endcase
	endfunction

	// Address and data of write number step
	function automatic logic [26:0] cmd_word(input fps_op_t op, input logic [2:0] step,
			input logic [18:0] a, input logic [7:0] d);
		cmd_word = {a, d};
		if (op == OP_SUSP) begin
			cmd_word = {a, CMD_SUSP};
		end else if (op == OP_RESUME) begin
			cmd_word = {a, CMD_RESUME};
		end else if (op == OP_RESET) begin
			cmd_word = {a, CMD_RESET};
		end else if (op == OP_PROG && step == 3'h3) begin
			cmd_word = {a, d};
		end else if (op == OP_ERASE && step == 3'h5) begin
			cmd_word = {a, CMD_SECT};
		end else if (step == 3'h1 || step == 3'h4) begin
			cmd_word = {UNLK_A2, UNLK_D2};
		end else if (step == 3'h2) begin
			cmd_word = {UNLK_A1, (op == OP_PROG) ? CMD_PROG : CMD_ERASE_SET};
		end else begin
			cmd_word = {UNLK_A1, UNLK_D1};
		end
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic acc;
		logic stable;
		logic polls;
		logic [26:0] cw;
		nx = st;
		acc = wb_cyc_i && wb_stb_i && !st.ack;
		// Two reads with the same first toggle bit: the operation has ended
		stable = (st.nrd == 2'h2) && (st.rd_cur[TOG1_BIT] == st.rd_prev[TOG1_BIT]);
		polls = (st.op == OP_PROG) || (st.op == OP_SUSP) || (st.op == OP_POLL);
		cw = cmd_word(st.op, st.step, st.addr_reg, st.wdata);
		nx.ack = acc;
		if (st.gap != 20'h00000) begin
			nx.gap = st.gap - 20'h00001;
		end

		// Register writes are ignored while an operation runs
		if (acc && wb_we_i && wb_sel_i[0] && !st.busy) begin
			case (wb_adr_i)
				REG_CTRL: if (wb_dat_i[2:0] != 3'h7) begin
					nx.op = fps_op_t'(wb_dat_i[2:0]);
					nx.busy = 1'b1;
					nx.done = 1'b0;
					nx.fail = 1'b0;
					nx.step = 3'h0;
					nx.nrd = 2'h0;
					nx.tmo_seen = 1'b0;
					nx.state = S_NEXT;
				end
				REG_ADDR: nx.addr_reg = wb_dat_i[18:0];
				REG_WDATA: nx.wdata = wb_dat_i[7:0];
				default: ;
			endcase
		end
		if (acc && !wb_we_i) begin
			case (wb_adr_i)
				REG_CTRL: nx.dat = {29'h0, st.op};
				REG_ADDR: nx.dat = {13'h0, st.addr_reg};
				REG_WDATA: nx.dat = {24'h0, st.wdata};
				REG_STAT: nx.dat = {27'h0, st.gap != 20'h00000, st.susp, st.fail, st.done, st.busy};
				REG_RDATA: nx.dat = {24'h0, st.rd_cur};
				default: nx.dat = 32'h0;
			endcase
		end

		// Pin sequencer: address, chip enable, strobe, release
		unique case (st.state)
			S_IDLE: ;
			S_NEXT: begin
				if (st.step < nwr(st.op)) begin
					// Hold a suspend until the post-resume gap has run out
					if (!(st.op == OP_SUSP && st.gap != 20'h00000)) begin
						nx.pins.addr = cw[26:8];
						nx.pins.dq = cw[7:0];
						nx.pins.dq_oe = 1'b1;
						nx.pins.ce_n = 1'b0;
						nx.is_rd = 1'b0;
						nx.state = S_SETUP;
					end
				end else if ((st.op == OP_READ) || polls) begin
					nx.pins.addr = st.addr_reg;
					nx.pins.ce_n = 1'b0;
					nx.is_rd = 1'b1;
					nx.state = S_SETUP;
				end else begin
					nx.busy = 1'b0;
					nx.done = !st.fail;
					nx.state = S_IDLE;
				end
			end
			S_SETUP: begin
				// Strobe falls after chip enable: address latched on this later edge
				nx.pins.we_n = st.is_rd;
				nx.pins.oe_n = !st.is_rd;
				nx.tcnt = st.is_rd ? 4'(RD_CYC - 1) : 4'(WP_CYC - 1);
				nx.state = S_STROBE;
			end
			S_STROBE: begin
				if (st.tcnt != 4'h0) begin
					nx.tcnt = st.tcnt - 4'h1;
				end else begin
					nx.pins.we_n = 1'b1;
					nx.pins.oe_n = 1'b1;
					if (st.is_rd) begin
						nx.rd_prev = st.rd_cur;
						nx.rd_cur = fl_dq_i;
						nx.nrd = (st.nrd == 2'h2) ? 2'h2 : st.nrd + 2'h1;
					end
					nx.state = S_HOLD;
				end
			end
			S_HOLD: begin
				nx.pins.ce_n = 1'b1;
				nx.pins.dq_oe = 1'b0;
				nx.state = S_NEXT;
				if (!st.is_rd) begin
					nx.step = st.step + 3'h1;
					if (st.op == OP_RESUME) begin
						nx.susp = 1'b0;
						nx.gap = 20'(GAP_CYC_P);
					end
				end else begin
					nx.tmo_seen = st.rd_cur[TMO_BIT];
					if (st.op == OP_READ) begin
						nx.busy = 1'b0;
						nx.done = 1'b1;
						nx.state = S_IDLE;
					end else if (stable) begin
						// Final read came after the polling bit turned true
						nx.busy = 1'b0;
						nx.state = S_IDLE;
						if (st.op == OP_PROG) begin
							// A zero in bit 7 or 6 that would not turn to one shows up as a mismatch
							nx.done = (st.rd_cur[7:6] == st.wdata[7:6]);
							nx.fail = (st.rd_cur[7:6] != st.wdata[7:6]);
						end else begin
							nx.done = 1'b1;
							nx.susp = (st.op == OP_SUSP) && st.rd_cur[DPOLL_BIT];
						end
					end else if (st.tmo_seen) begin
						// Still toggling after the timeout flag: abort with reset
						nx.fail = 1'b1;
						nx.op = OP_RESET;
						nx.step = 3'h0;
					end
				end
			end
		endcase
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0;
			st.state <= S_IDLE;
			st.pins <= PINS_IDLE;
		end else begin
			st <= nx;
		end
	end

	assign wb_dat_o = st.dat;
	assign wb_ack_o = st.ack;
	assign pins_o = st.pins;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_no_dq_contention: assert property (st.pins.dq_oe |-> st.pins.oe_n)
		else $error("dq driven while output enable low");
	a_we_oe_excl: assert property (!st.pins.we_n |-> st.pins.oe_n && !st.pins.ce_n)
		else $error("write strobe without chip enable or with output enable");
	a_write_stable: assert property (!st.pins.we_n && $past(!st.pins.we_n)
		|-> $stable(st.pins.addr) && $stable(st.pins.dq))
		else $error("address or data moved during write strobe");
	a_write_width: assert property ($fell(st.pins.we_n)
		|-> (!st.pins.we_n)[*5] ##1 st.pins.we_n)
		else $error("write strobe width wrong");
	a_susp_gap: assert property (!st.pins.we_n && st.op == OP_SUSP
		|-> st.gap == 20'h00000)
		else $error("suspend issued inside resume gap");
	a_poll_addr: assert property (!st.pins.oe_n && st.op != OP_READ
		|-> st.pins.addr == st.addr_reg)
		else $error("status read at wrong address");
	a_prog_done: assert property ($rose(st.done) && st.op == OP_PROG
		|-> st.rd_cur[7:6] == st.wdata[7:6] && st.rd_cur[6] == st.rd_prev[6])
		else $error("program done without matching steady read");
	a_resume_gap: assert property ($fell(st.susp) |-> st.gap == 20'(GAP_CYC_P))
		else $error("resume did not start the gap");
	a_susp_seen: assert property ($rose(st.susp)
		|-> st.rd_cur[DPOLL_BIT] && st.rd_cur[TOG1_BIT] == st.rd_prev[TOG1_BIT])
		else $error("suspend flagged without suspended status");
	a_fail_reset: assert property ($rose(st.fail) && st.op == OP_RESET
		|-> ##[1:20] (!st.pins.we_n && st.pins.dq == CMD_RESET))
		else $error("timeout failure not followed by reset write");
	a_ack_pulse: assert property (st.ack |=> !st.ack)
		else $error("ack held longer than one cycle");
endmodule // fps_host
`default_nettype wire

/* hw/fps_pkg.sv */
/*
 * Shared constants and types for the flash command and status host:
 * register map, flash command codes, status bit positions, pin timing.
 * Assumes a 100 MHz clock and a byte-wide asynchronous flash on the pins.
 */
`default_nettype none
package fps_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_NS = 10;
	localparam int T_RD_NS = 120; // Read strobe covers the access time
	localparam int T_WP_NS = 50;
	localparam int RD_CYC = (T_RD_NS + CLK_NS - 1) / CLK_NS;
	localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int GAP_MS = 10;
	localparam int GAP_CYC = GAP_MS * 1000000 / CLK_NS;

	// ----------------------------------------
	// Register map offsets
	// ----------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0c;
	localparam logic [7:0] REG_RDATA = 8'h10;

	// ----------------------------------------
	// Flash command codes and status bits
	// ----------------------------------------
	localparam logic [18:0] UNLK_A1 = 19'h00555;
	localparam logic [18:0] UNLK_A2 = 19'h002aa;
	localparam logic [7:0] UNLK_D1 = 8'haa;
	localparam logic [7:0] UNLK_D2 = 8'h55;
	localparam logic [7:0] CMD_PROG = 8'ha0;
	localparam logic [7:0] CMD_ERASE_SET = 8'h80;
	localparam logic [7:0] CMD_SECT = 8'h30;
	localparam logic [7:0] CMD_SUSP = 8'hb0;
	localparam logic [7:0] CMD_RESUME = 8'h30;
	localparam logic [7:0] CMD_RESET = 8'hf0;
	localparam int DPOLL_BIT = 7;
	localparam int TOG1_BIT = 6;
	localparam int TMO_BIT = 5;

	typedef enum logic [2:0] {
		OP_READ = 3'h0, OP_PROG = 3'h1, OP_ERASE = 3'h2, OP_SUSP = 3'h3,
		OP_RESUME = 3'h4, OP_RESET = 3'h5, OP_POLL = 3'h6
	} fps_op_t;

	typedef enum logic [4:0] {
		S_IDLE = 5'h01, S_NEXT = 5'h02, S_SETUP = 5'h04, S_STROBE = 5'h08, S_HOLD = 5'h10
	} fps_state_t;

	typedef struct packed {
		logic ce_n;
		logic we_n;
		logic oe_n;
		logic [18:0] addr;
		logic [7:0] dq;
		logic dq_oe;
	} fps_pins_t;

	localparam fps_pins_t PINS_IDLE = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
		addr: 19'h00000, dq: 8'h00, dq_oe: 1'b0};

	typedef struct packed {
		fps_state_t state;
		fps_op_t op;
		logic [2:0] step;
		logic is_rd;
		logic [3:0] tcnt;
		logic [19:0] gap;
		fps_pins_t pins;
		logic [18:0] addr_reg;
		logic [7:0] wdata;
		logic [7:0] rd_cur;
		logic [7:0] rd_prev;
		logic [1:0] nrd;
		logic tmo_seen;
		logic busy;
		logic done;
		logic fail;
		logic susp;
		logic ack;
		logic [31:0] dat;
	} fps_host_t;
endpackage
`default_nettype wire

/* tb/fps_flash_model.sv */
/* Behavioural byte-wide flash with command decode and status reads.
 Assumes pins registered on clk_i by the host; one page shared by all sectors. */
`timescale 1ns/10ps
`default_nettype none
module fps_flash_model (
	input wire logic clk_i,
	input wire fps_pkg::fps_pins_t pins_i,
	input wire logic tmo_i,
	output logic [7:0] dq_o
);
	import fps_pkg::*;
	logic [7:0] mem [16];
	logic [7:0] pd = 0, rv = 0;
	logic [2:0] es = 0;
	logic [1:0] sq = 0;
	logic [9:0] pc = 0, ec = 0;
	logic arm = 0, su = 0, tf = 0, t1 = 0, t2 = 0, wp = 1, op = 1;
	wire pb = pc != 0;
	wire eb = ec != 0 && !su;
	// Released bus shows the inverse of the last byte, never a stale copy
	assign dq_o = pins_i.oe_n ? ~rv : rv;
	initial foreach (mem[i]) mem[i] = 8'hff;
	// ----
	// Command writes, taken as the write strobe rises
	// ----
	task wr(input logic [18:0] a, input logic [7:0] d);
		if (pb && !tf) return;
		sq <= 0;
		// Program data is decoded first, so a data byte that looks like a command is still stored
		if (sq == 3) begin
			// Top sector is protected: status shows for 100 cycles instead of 40, array stays untouched
			if (a[18:16] != 3'h7) mem[a[3:0]] <= mem[a[3:0]] & d;
			{pd, pc, tf} <= {d, (a[18:16] == 3'h7) ? 10'h064 : 10'h028, tmo_i};
		end
		else if (d == CMD_RESET) {tf, pc, arm} <= '0;
		else if (d == CMD_SUSP && eb) su <= 1;
		else if (d == CMD_SECT && sq == 2 && arm) {ec, es, arm} <= {10'h258, a[18:16], 1'b0};
		else if (d == CMD_RESUME && su && sq == 0) su <= 0;
		else if (d == UNLK_D1 && a == UNLK_A1) sq <= 1;
		else if (d == UNLK_D2 && a == UNLK_A2 && sq == 1) sq <= 2;
		else if (d == CMD_PROG && sq == 2) sq <= 3;
		else if (d == CMD_ERASE_SET && sq == 2 && !su) arm <= 1;
	endtask
	// Status or array byte for one read cycle
	task rd(input logic [18:0] a);
		if (pb) rv <= {~pd[7], t1, tf, 5'h00};
		else if (eb) rv <= {1'b0, t1, 2'b00, 1'b1, t2 && a[18:16] == es, 2'b00};
		else if (su && a[18:16] == es) rv <= {1'b1, t1, 3'b000, t2, 2'b00};
		else rv <= mem[a[3:0]];
		if (pb || eb) t1 <= ~t1;
		if ((eb || su) && a[18:16] == es) t2 <= ~t2;
	endtask
	// Self-timed program and erase; suspend freezes the erase count
	always @(posedge clk_i) begin
		wp <= pins_i.we_n;
		op <= pins_i.oe_n;
		if (pb && !tf) pc <= pc - 10'h1;
		if (eb) ec <= ec - 10'h1;
		// A protected selected sector keeps its contents when the erase ends
		if (eb && ec == 10'h1 && es != 3'h7) foreach (mem[i]) mem[i] <= 8'hff;
		if (!wp && pins_i.we_n && !pins_i.ce_n) wr(pins_i.addr, pins_i.dq);
		if (op && !pins_i.oe_n && !pins_i.ce_n) rd(pins_i.addr);
	end
endmodule // fps_flash_model
`default_nettype wire

/* tb/fps_host_tb.sv */
/* Self-checking bench for fps_host against the flash model.
 Assumes one-cycle Wishbone ack and op codes from the package. */
`timescale 1ns/10ps
`default_nettype none
module fps_host_tb;
	import fps_pkg::*;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, tmo = 0, wb_ack_o;
	logic [7:0] adr = 0, fl_dq;
	logic [7:0] d [3];
	logic [3:0] sel = 0;
	logic [31:0] dat = 0, q, wb_dat_o;
	logic [31:0] eq [$], mq [$];
	int errors = 0, tests_run = 0;
	fps_pins_t pins;
	fps_host #(.GAP_CYC_P(50)) u_fps_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pins_o(pins), .fl_dq_i(fl_dq));
	fps_flash_model u_fps_flash_model (.clk_i(clk_i), .pins_i(pins), .tmo_i(tmo), .dq_o(fl_dq));
	initial forever #5 clk_i = ~clk_i;
	// Oldest note is checked against each read answer
	always @(posedge clk_i) if (wb_ack_o && !we) begin
		if (mq[0] != 0) tests_run++;
		if ((wb_dat_o & mq[0]) !== eq[0]) begin
			errors++;
			$display("ERROR reg %h exp %h got %h", adr, eq[0], wb_dat_o & mq[0]);
		end
		void'(eq.pop_front());
		void'(mq.pop_front());
	end
	// One classic cycle; held until ack is sampled
	task wb(input logic w, input logic [7:0] a, input logic [31:0] v);
		int n;
		n = 0;
		@(posedge clk_i);
		{cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, v, 4'hf};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 200);
		if (wb_ack_o !== 1'b1) begin
			errors++;
			$display("ERROR ack for reg %h exp 1 got %b", a, wb_ack_o);
		end
		q = wb_dat_o;
		{cyc, stb} <= 2'b00;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		eq.push_back(e & m);
		mq.push_back(m);
		wb(0, a, 0);
	endtask
	// Start an op and poll busy until it falls
	task run(input logic [2:0] o, input logic [18:0] a, input logic [7:0] v);
		int n;
		n = 0;
		wb(1, REG_ADDR, 32'(a));
		wb(1, REG_WDATA, 32'(v));
		wb(1, REG_CTRL, 32'(o));
		do rd(REG_STAT, 0, 0); while (q[0] !== 1'b0 && ++n < 999);
		if (q[0] !== 1'b0) begin
			errors++;
			$display("ERROR busy for op %0d exp 0 got %b", o, q[0]);
		end
	endtask
	task final_report;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		void'($urandom(38419));
		repeat (16) @(posedge clk_i);
		rst_i <= 0;
		rd(REG_STAT, 0, 32'hffffffff);
		rd(8'h14, 0, 32'hffffffff);
		for (int i = 0; i < 3; i++) begin
			d[i] = 8'($urandom) & (i ? 8'hff : 8'h3f);
			run(OP_PROG, 19'(i), d[i]);
			rd(REG_STAT, 2, 7);
			rd(REG_RDATA, d[i], 8'hff);
		end
		run(OP_PROG, 0, 8'hff);
		rd(REG_STAT, 4, 7);
		rd(REG_RDATA, d[0], 8'hff);
		run(OP_PROG, 19'h70003, 0);
		rd(REG_STAT, 4, 7);
		tmo <= 1;
		run(OP_PROG, 5, 0);
		rd(REG_STAT, 4, 7);
		tmo <= 0;
		run(OP_SUSP, 0, 0);
		rd(REG_STAT, 0, 8);
		run(OP_ERASE, 19'h10008, 0);
		run(OP_SUSP, 19'h10008, 0);
		rd(REG_STAT, 8, 8);
		run(OP_READ, 19'h10008, 0);
		rd(REG_RDATA, 8'h80, 8'ha0);
		run(OP_READ, 1, 0);
		rd(REG_RDATA, d[1], 8'hff);
		run(OP_PROG, 9, d[2]);
		rd(REG_STAT, 2, 7);
		run(OP_RESUME, 19'h10008, 0);
		rd(REG_STAT, 8'h10, 8'h18);
		run(OP_SUSP, 19'h10008, 0);
		rd(REG_STAT, 8, 8'h18);
		run(OP_RESUME, 19'h10008, 0);
		run(OP_POLL, 19'h10008, 8'hff);
		rd(REG_STAT, 2, 7);
		run(OP_READ, 0, 0);
		rd(REG_RDATA, 8'hff, 8'hff);
		run(OP_RESET, 0, 0);
		rd(REG_STAT, 0, 1);
		final_report;
	end
	// Watchdog well past the expected run length
	initial begin
		repeat (60000) @(posedge clk_i);
		errors++;
		final_report;
	end
endmodule // fps_host_tb
`default_nettype wire
